// ===== include/fault_mon_regs.vh
// register map, reset values and timing constants for the fault condition monitor
`ifndef FAULT_MON_REGS_VH
`define FAULT_MON_REGS_VH

// ----------------------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS      32'h00000008
`define HALF_SEC_NS        32'h1DCD6500
`define HALF_SEC_CYCLES    (`HALF_SEC_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// address map: bit 6 picks the input, bits 5:0 the register, bit 7 unmapped
// ----------------------------------------------------------------------------
`define ADDR_INPUT_BIT     6
`define ADDR_UNMAPPED_BIT  7
`define OFF_CTRL           6'h00
`define OFF_ENABLE         6'h04
`define OFF_NOISE          6'h08
`define OFF_FREEZE_DUR     6'h0C
`define OFF_BLACK_DUR      6'h10
`define OFF_OVER_THR       6'h14
`define OFF_OVER_CNT       6'h18
`define OFF_SIL_THR        6'h1C
`define OFF_SIL_DUR        6'h20
`define OFF_INV_DUR        6'h24
`define OFF_HOLD           6'h28
`define OFF_RELEASE        6'h2C
`define OFF_STATUS         6'h30

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CTRL_AND_BIT       0
`define STATUS_FAULT_BIT   24
`define COND_VLOSS         0
`define COND_FREEZE        1
`define COND_BLACK         2
`define COND_GLOSS         3
`define COND_OVER          7
`define COND_SILENCE       11
`define COND_PHASE         15
`define COND_MONO          19
`define COND_INVALID       23

// ----------------------------------------------------------------------------
// reset values and legal ranges (levels in quarter-dB below full scale)
// ----------------------------------------------------------------------------
`define RST_ENABLE         24'h000001
`define RST_NOISE          10'h009
`define NOISE_MIN          10'h001
`define NOISE_MAX          10'h00A
`define RST_FREEZE_DUR     10'h12E
`define FREEZE_MIN         10'h006
`define FREEZE_MAX         10'h386
`define FREEZE_STEP_MASK   10'h003
`define RST_BLACK_DUR      10'h058
`define BLACK_MIN          10'h004
`define BLACK_MAX          10'h384
`define RST_OVER_THR       10'h018
`define OVER_THR_MAX       10'h078
`define RST_OVER_CNT       10'h003
`define OVER_CNT_MIN       10'h003
`define OVER_CNT_MAX       10'h0FF
`define RST_SIL_THR        10'h0F0
`define SIL_THR_MIN        10'h050
`define SIL_THR_MAX        10'h180
`define RST_SIL_DUR        10'h014
`define HALFSEC_MIN        10'h001
`define HALFSEC_MAX        10'h0FE
`define RST_INV_DUR        10'h000
`define INV_MAX            10'h384
`define RST_HOLD           10'h01E
`define HOLD_MAX           10'h0FE
`define RST_RELEASE        10'h002
`define SIL_REMOVE_HALFSEC 10'h002
`define BLACK_LEVEL        10'h07D

`endif

// ===== design/dur_qual.v
// duration qualifier: flags a condition that has held for a number of ticks
`timescale 1ns/1ps
`default_nettype none

module dur_qual #(
  parameter W = 10
) (
  // clock and reset
  input  wire         sys_clk_i,
  input  wire         srst_i,
  // condition, time base and limit
  input  wire         cond_i,
  input  wire         tick_i,
  input  wire [W-1:0] limit_i,
  // qualified condition
  output wire         met_o
);

  reg [W-1:0] cnt_r;  // ticks seen while the condition held

  // ----------------------------------------------------------------------------
  // counter: any break in the condition restarts the count
  // ----------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (srst_i || !cond_i) begin
      cnt_r <= {W{1'b0}};
    end else if (tick_i && (cnt_r != {W{1'b1}})) begin
      // saturate so a long condition never wraps back to zero
      cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
    end
  end

  // a zero limit qualifies at once
  assign met_o = cond_i && (cnt_r >= limit_i);

endmodule // dur_qual

`default_nettype wire

// ===== design/av_fault_condition_monitor.v
// per-input video and embedded audio fault monitor with its register file
//
// Functional notes
// - enabled conditions combine by OR or AND
// - per-condition enables; default only video loss
// - video loss instant; invalid needs duration
// - video, group loss, per-pair audio conditions
// - freeze noise threshold 1..10, default 9
// - freeze duration 6..902 frames, steps four
// - freeze when activity stays under threshold
// - black when active picture below 7 IRE
// - black duration 4..900 frames, default 88
// - over threshold 0..-30 dBFS, quarter dB
// - over count 3..255 consecutive samples
// - any single channel raises pair over
// - zero dBFS threshold catches clipping
// - silence needs both pair channels quiet
// - silence removed after one loud second
// - silence threshold -96..-20 dBFS, default -60
// - silence duration 0.5..127 s, half steps
// - fault held until clear or 1..254 frames
// - fault released after configurable time, default 1 s
`include "fault_mon_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module av_fault_condition_monitor #(
  parameter [31:0] HALF_SEC_CYCLES = `HALF_SEC_CYCLES
) (
  // clock and reset
  input  wire         sys_clk_i,
  input  wire         srst_i,
  // register port
  input  wire [7:0]   addr_i,
  input  wire [31:0]  wdata_i,
  input  wire         wr_i,
  input  wire         rd_i,
  output reg  [31:0]  rdata_o,
  // video measurements, input 0 in the low slice
  input  wire [1:0]   frame_tick_i,
  input  wire [1:0]   video_loss_i,
  input  wire [1:0]   video_invalid_i,
  input  wire [15:0]  picture_activity_i,
  input  wire [19:0]  active_luma_max_i,
  // embedded audio measurements
  input  wire [1:0]   audio_sample_stb_i,
  input  wire [7:0]   group_present_i,
  input  wire [143:0] channel_atten_i,
  input  wire [7:0]   pair_phase_i,
  input  wire [7:0]   pair_mono_i,
  // fault outputs
  output reg  [1:0]   fault_o
);

  // ----------------------------------------------------------------------------
  // clamp helper for written settings
  // ----------------------------------------------------------------------------
  function [9:0] clamp10;
    input [9:0] v;
    input [9:0] lo;
    input [9:0] hi;
    begin
      clamp10 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // ----------------------------------------------------------------------------
  // half-second time base, shared by both inputs
  // ----------------------------------------------------------------------------
  reg  [31:0] half_cnt_r;  // cycles into the current half second
  reg         half_tick_r; // one-cycle pulse each half second

  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      half_cnt_r  <= 32'h00000000;
      half_tick_r <= 1'b0;
    end else if (half_cnt_r >= HALF_SEC_CYCLES - 32'h00000001) begin
      half_cnt_r  <= 32'h00000000;
      half_tick_r <= 1'b1;
    end else begin
      half_cnt_r  <= half_cnt_r + 32'h00000001;
      half_tick_r <= 1'b0;
    end
  end

  wire [5:0]  off     = addr_i[5:0];
  wire [9:0]  wv      = wdata_i[9:0];
  wire [63:0] rd_word;          // read word offered by each input
  wire [1:0]  fault_w;          // fault state of each input

  // ----------------------------------------------------------------------------
  // one full monitor per video input
  // ----------------------------------------------------------------------------
  genvar g, c, p;
  generate
    for (g = 0; g < 2; g = g + 1) begin : inp
      // selected for a write
      wire we = wr_i && !addr_i[`ADDR_UNMAPPED_BIT] && (addr_i[`ADDR_INPUT_BIT] == g);

      // settings
      reg        and_r;         // combine by AND when set
      reg [23:0] en_r;          // per-condition enables
      reg [9:0]  noise_r;       // freeze noise threshold
      reg [9:0]  frz_dur_r;     // freeze duration, frames
      reg [9:0]  blk_dur_r;     // black duration, frames
      reg [9:0]  ovr_thr_r;     // over level, quarter dB below full scale
      reg [9:0]  ovr_cnt_r;     // over run length, samples
      reg [9:0]  sil_thr_r;     // silence level, quarter dB below full scale
      reg [9:0]  sil_dur_r;     // silence duration, half seconds
      reg [9:0]  inv_dur_r;     // invalid duration, frames
      reg [9:0]  hold_r;        // hold time in frames, zero holds until clear
      reg [9:0]  rel_r;         // release time, half seconds
      reg [9:0]  frz_c;         // clamped freeze write before stepping

      // ----------------------------------------------------------------------------
      // setting writes, clamped so the logic never sees an illegal value
      // ----------------------------------------------------------------------------
      always @* begin
        frz_c = clamp10(wv, `FREEZE_MIN, `FREEZE_MAX);
      end

      always @(posedge sys_clk_i) begin
        if (srst_i) begin
          and_r     <= 1'b0;
          en_r      <= `RST_ENABLE;
          noise_r   <= `RST_NOISE;
          frz_dur_r <= `RST_FREEZE_DUR;
          blk_dur_r <= `RST_BLACK_DUR;
          ovr_thr_r <= `RST_OVER_THR;
          ovr_cnt_r <= `RST_OVER_CNT;
          sil_thr_r <= `RST_SIL_THR;
          sil_dur_r <= `RST_SIL_DUR;
          inv_dur_r <= `RST_INV_DUR;
          hold_r    <= `RST_HOLD;
          rel_r     <= `RST_RELEASE;
        end else if (we) begin
          case (off)
            `OFF_CTRL:       and_r     <= wdata_i[`CTRL_AND_BIT];
            `OFF_ENABLE:     en_r      <= wdata_i[23:0];
            `OFF_NOISE:      noise_r   <= clamp10(wv, `NOISE_MIN, `NOISE_MAX);
            // the step of four is kept by dropping the remainder above the floor
            `OFF_FREEZE_DUR: frz_dur_r <= frz_c - ((frz_c - `FREEZE_MIN) & `FREEZE_STEP_MASK);
            `OFF_BLACK_DUR:  blk_dur_r <= clamp10(wv, `BLACK_MIN, `BLACK_MAX);
            `OFF_OVER_THR:   ovr_thr_r <= clamp10(wv, 10'h000, `OVER_THR_MAX);
            `OFF_OVER_CNT:   ovr_cnt_r <= clamp10(wv, `OVER_CNT_MIN, `OVER_CNT_MAX);
            `OFF_SIL_THR:    sil_thr_r <= clamp10(wv, `SIL_THR_MIN, `SIL_THR_MAX);
            `OFF_SIL_DUR:    sil_dur_r <= clamp10(wv, `HALFSEC_MIN, `HALFSEC_MAX);
            `OFF_INV_DUR:    inv_dur_r <= clamp10(wv, 10'h000, `INV_MAX);
            `OFF_HOLD:       hold_r    <= clamp10(wv, 10'h000, `HOLD_MAX);
            `OFF_RELEASE:    rel_r     <= clamp10(wv, 10'h000, `HALFSEC_MAX);
            default:         and_r     <= and_r;
          endcase
        end
      end

      // ----------------------------------------------------------------------------
      // video detectors: measurements latched once per frame
      // ----------------------------------------------------------------------------
      wire       ftick = frame_tick_i[g];
      reg        still_r;                                           // frame under noise level
      reg        dark_r;                                            // frame under black level
      wire       frz_met;
      wire       blk_met;
      wire       inv_met;

      always @(posedge sys_clk_i) begin
        if (srst_i) begin
          still_r <= 1'b0;
          dark_r  <= 1'b0;
        end else if (ftick) begin
          // a setting of 1 lets only a zero difference count as still
          still_r <= ({2'b00, picture_activity_i[8*g +: 8]} < noise_r);
          dark_r  <= (active_luma_max_i[10*g +: 10] < `BLACK_LEVEL);
        end
      end

      dur_qual #(.W(10)) u_frz (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .cond_i    (still_r),
        .tick_i    (ftick),
        .limit_i   (frz_dur_r),
        .met_o     (frz_met)
      );
      dur_qual #(.W(10)) u_blk (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .cond_i    (dark_r),
        .tick_i    (ftick),
        .limit_i   (blk_dur_r),
        .met_o     (blk_met)
      );
      dur_qual #(.W(10)) u_inv (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .cond_i    (video_invalid_i[g]),
        .tick_i    (ftick),
        .limit_i   (inv_dur_r),
        .met_o     (inv_met)
      );

      // ----------------------------------------------------------------------------
      // audio over: each channel counts its own run of loud samples
      // ----------------------------------------------------------------------------
      wire [7:0] ch_over;
      for (c = 0; c < 8; c = c + 1) begin : ch
        // zero attenuation is the max or min code, so a zero threshold is a clip test
        wire loud = ({1'b0, channel_atten_i[72*g + 9*c +: 9]} <= ovr_thr_r);
        wire run;
        dur_qual #(.W(8)) u_ovr (
          .sys_clk_i (sys_clk_i),
          .srst_i    (srst_i),
          .cond_i    (run),
          .tick_i    (audio_sample_stb_i[g]),
          .limit_i   (ovr_cnt_r[7:0]),
          .met_o     (ch_over[c])
        );
        // the run lasts while the latest sample stayed loud
        reg loud_r;
        always @(posedge sys_clk_i) begin
          if (srst_i) begin
            loud_r <= 1'b0;
          end else if (audio_sample_stb_i[g]) begin
            loud_r <= loud;
          end
        end
        // count the strobe that carries the next loud sample as well
        assign run = audio_sample_stb_i[g] ? loud : loud_r;
      end

      // ----------------------------------------------------------------------------
      // audio silence: both channels quiet, removed after one loud second
      // ----------------------------------------------------------------------------
      wire [3:0] pair_sil;
      for (p = 0; p < 4; p = p + 1) begin : pr
        reg  quiet_r;           // both channels under the silence level
        reg  sil_r;             // asserted silence condition
        wire sil_met;
        wire rem_met;
        always @(posedge sys_clk_i) begin
          if (srst_i) begin
            quiet_r <= 1'b0;
          end else if (audio_sample_stb_i[g]) begin
            quiet_r <= ({1'b0, channel_atten_i[72*g + 18*p +: 9]} > sil_thr_r) &&
                       ({1'b0, channel_atten_i[72*g + 18*p + 9 +: 9]} > sil_thr_r);
          end
        end
        dur_qual #(.W(10)) u_sil (
          .sys_clk_i (sys_clk_i),
          .srst_i    (srst_i),
          .cond_i    (quiet_r),
          .tick_i    (half_tick_r),
          .limit_i   (sil_dur_r),
          .met_o     (sil_met)
        );
        dur_qual #(.W(10)) u_rem (
          .sys_clk_i (sys_clk_i),
          .srst_i    (srst_i),
          .cond_i    (sil_r && !quiet_r),
          .tick_i    (half_tick_r),
          .limit_i   (`SIL_REMOVE_HALFSEC),
          .met_o     (rem_met)
        );
        always @(posedge sys_clk_i) begin
          if (srst_i) begin
            sil_r <= 1'b0;
          end else if (sil_met) begin
            sil_r <= 1'b1;
          end else if (rem_met) begin
            sil_r <= 1'b0;
          end
        end
        assign pair_sil[p] = sil_r;
      end

      // ----------------------------------------------------------------------------
      // condition vector, in menu order
      // ----------------------------------------------------------------------------
      wire [23:0] cond;
      assign cond[`COND_VLOSS]           = video_loss_i[g];
      assign cond[`COND_FREEZE]          = frz_met;
      assign cond[`COND_BLACK]           = blk_met;
      assign cond[`COND_GLOSS +: 4]      = ~group_present_i[4*g +: 4];
      assign cond[`COND_OVER +: 4]       = {ch_over[7] | ch_over[6], ch_over[5] | ch_over[4],
                                            ch_over[3] | ch_over[2], ch_over[1] | ch_over[0]};
      assign cond[`COND_SILENCE +: 4]    = pair_sil;
      assign cond[`COND_PHASE +: 4]      = pair_phase_i[4*g +: 4];
      assign cond[`COND_MONO +: 4]       = pair_mono_i[4*g +: 4];
      assign cond[`COND_INVALID]         = inv_met;

      // ----------------------------------------------------------------------------
      // combine, hold and release
      // ----------------------------------------------------------------------------
      // with nothing enabled AND never fires, so an empty set cannot raise a fault
      wire raw = and_r ? ((en_r != 24'h000000) && ((cond & en_r) == en_r))
                       : ((cond & en_r) != 24'h000000);
      reg        fault_r;       // asserted fault
      reg  [9:0] held_r;        // frames since the fault asserted
      wire       rel_met;
      wire       clr = we && (off == `OFF_STATUS);

      dur_qual #(.W(10)) u_rel (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .cond_i    (fault_r && !raw),
        .tick_i    (half_tick_r),
        .limit_i   (rel_r),
        .met_o     (rel_met)
      );

      always @(posedge sys_clk_i) begin
        if (srst_i) begin
          fault_r <= 1'b0;
          held_r  <= 10'h000;
        end else begin
          // a live condition beats a clear in the same cycle
          if (raw) begin
            fault_r <= 1'b1;
          end else if (hold_r == 10'h000) begin
            if (clr) begin
              fault_r <= 1'b0;
            end
          end else if ((held_r >= hold_r) && rel_met) begin
            fault_r <= 1'b0;
          end
          if (!fault_r) begin
            held_r <= 10'h000;
          end else if (ftick && (held_r != 10'h3FF)) begin
            held_r <= held_r + 10'h001;
          end
        end
      end
      assign fault_w[g] = fault_r;

      // ----------------------------------------------------------------------------
      // read word for this input
      // ----------------------------------------------------------------------------
      reg [31:0] rw;
      always @* begin
        rw = 32'h00000000;
        case (off)
          `OFF_CTRL:       rw[`CTRL_AND_BIT] = and_r;
          `OFF_ENABLE:     rw[23:0] = en_r;
          `OFF_NOISE:      rw[9:0]  = noise_r;
          `OFF_FREEZE_DUR: rw[9:0]  = frz_dur_r;
          `OFF_BLACK_DUR:  rw[9:0]  = blk_dur_r;
          `OFF_OVER_THR:   rw[9:0]  = ovr_thr_r;
          `OFF_OVER_CNT:   rw[9:0]  = ovr_cnt_r;
          `OFF_SIL_THR:    rw[9:0]  = sil_thr_r;
          `OFF_SIL_DUR:    rw[9:0]  = sil_dur_r;
          `OFF_INV_DUR:    rw[9:0]  = inv_dur_r;
          `OFF_HOLD:       rw[9:0]  = hold_r;
          `OFF_RELEASE:    rw[9:0]  = rel_r;
          `OFF_STATUS:     rw       = {7'h00, fault_r, cond};
          default:         rw       = 32'h00000000;
        endcase
      end
      assign rd_word[32*g +: 32] = rw;
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // read data one cycle after the strobe, zero otherwise or when unmapped
  // ----------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (srst_i || !rd_i || addr_i[`ADDR_UNMAPPED_BIT]) begin
      rdata_o <= 32'h00000000;
    end else begin
      rdata_o <= rd_word[32*addr_i[`ADDR_INPUT_BIT] +: 32];
    end
  end

  // ----------------------------------------------------------------------------
  // fault outputs, registered once more so they come straight from flops
  // ----------------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      fault_o <= 2'b00;
    end else begin
      fault_o <= fault_w;
    end
  end

endmodule // av_fault_condition_monitor

`default_nettype wire

// ===== bench/fault_mon_asserts.sv
// checker: register port read-back properties of the fault monitor
`include "fault_mon_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module fault_mon_asserts (
  // clock, reset and register port
  input wire logic        sys_clk_i,
  input wire logic        srst_i,
  input wire logic [7:0]  addr_i,
  input wire logic        rd_i,
  input wire logic [31:0] rdata_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // a mapped read and its offset, either input copy
  wire logic       rd_ok = rd_i && !addr_i[7];
  wire logic [5:0] off   = addr_i[5:0];
  a_rdata_idle: // no read, no data
    assert property (!rd_i |=> rdata_o == 32'h0) else $error("read data not idle");
  a_unmapped_read:
    assert property (rd_i && addr_i[7] |=> rdata_o == 32'h0) else $error("unmapped read not zero");
  a_ctrl_bits:
    assert property (rd_ok && off == `OFF_CTRL |=> rdata_o[31:1] == 31'h0) else $error("ctrl width");
  a_enable_bits:
    assert property (rd_ok && off == `OFF_ENABLE |=> rdata_o[31:24] == 8'h0) else $error("enable width");
  a_noise_range:
    assert property (rd_ok && off == `OFF_NOISE |=> rdata_o >= `NOISE_MIN && rdata_o <= `NOISE_MAX)
      else $error("noise out of range");
  a_freeze_step:
    assert property (rd_ok && off == `OFF_FREEZE_DUR |=> rdata_o[1:0] == 2'h2 && rdata_o <= `FREEZE_MAX)
      else $error("freeze off step");
  a_black_range:
    assert property (rd_ok && off == `OFF_BLACK_DUR |=> rdata_o >= `BLACK_MIN && rdata_o <= `BLACK_MAX)
      else $error("black out of range");
  a_over_count:
    assert property (rd_ok && off == `OFF_OVER_CNT |=> rdata_o >= `OVER_CNT_MIN && rdata_o <= `OVER_CNT_MAX)
      else $error("over count out of range");
  a_silence_level:
    assert property (rd_ok && off == `OFF_SIL_THR |=> rdata_o >= `SIL_THR_MIN && rdata_o <= `SIL_THR_MAX)
      else $error("silence level out of range");
endmodule // fault_mon_asserts
bind av_fault_condition_monitor fault_mon_asserts u_chk (.sys_clk_i, .srst_i, .addr_i, .rd_i, .rdata_o);
`default_nettype wire

// ===== bench/av_source_model.sv
// partner: frame ticks, audio sample strobes and channel levels
`timescale 1ns/1ps
`default_nettype none
module av_source_model (
  // clock and level request
  input wire logic          sys_clk_i,
  input wire logic [8:0]    level_i,
  // timing and audio towards the monitor
  output logic [1:0]   frame_tick_o,
  output logic [1:0]   sample_stb_o,
  output logic [143:0] atten_o
);
  logic [3:0] cnt_r = 4'h0; // short frames keep durations cheap to run
  // free phase counter; input 1 frames land half a frame later
  always_ff @(posedge sys_clk_i) cnt_r <= cnt_r + 4'h1;
  assign frame_tick_o = {cnt_r == 4'hB, cnt_r == 4'h3};
  assign sample_stb_o = {cnt_r[1:0] == 2'h3, cnt_r[1:0] == 2'h1};
  assign atten_o = {16{level_i}}; // same level on every channel
endmodule // av_source_model
`default_nettype wire

// ===== bench/av_fault_condition_monitor_test.sv
// testbench: register defaults, clamping and per-condition faults
`timescale 1ns/1ps
`default_nettype none
module av_fault_condition_monitor_test;
  logic sys_clk_i = 1'b0, srst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00, gp_r = 8'hFF, ph_r = 8'h00, mono_r = 8'h00;
  logic [31:0] wdata_i = 32'h0, d;
  logic [1:0] loss_r = 2'h0, inv_r = 2'h0;
  logic [15:0] act_r = 16'hFFFF; // busy picture: never frozen
  logic [19:0] luma_r = 20'hFFFFF; // bright picture: never black
  logic [8:0] lvl_r = 9'h040; // neither over nor silent
  wire logic [31:0] rdata_o;
  wire logic [1:0] fault_o, tick, stb;
  wire logic [143:0] atten;
  int err_total = 0, n_checks = 0;
  logic [31:0] dflt [14] = '{32'h0, 32'h1, 32'h9, 32'h12E, 32'h58, 32'h18, 32'h3,
                             32'hF0, 32'h14, 32'h0, 32'h1E, 32'h2, 32'h0, 32'h0};
  av_source_model src (.sys_clk_i, .level_i(lvl_r), .frame_tick_o(tick), .sample_stb_o(stb), .atten_o(atten));
  av_fault_condition_monitor #(.HALF_SEC_CYCLES(32'd10)) dut (.sys_clk_i, .srst_i, .addr_i, .wdata_i,
    .wr_i, .rd_i, .rdata_o, .frame_tick_i(tick), .video_loss_i(loss_r), .video_invalid_i(inv_r),
    .picture_activity_i(act_r), .active_luma_max_i(luma_r), .audio_sample_stb_i(stb),
    .group_present_i(gp_r), .channel_atten_i(atten), .pair_phase_i(ph_r), .pair_mono_i(mono_r), .fault_o);
  initial forever #4 sys_clk_i = ~sys_clk_i;
  // one-cycle write, then one-cycle read sampled after its answer lands
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i) {addr_i, wdata_i, wr_i} <= {a, v, 1'b1};
    @(posedge sys_clk_i) wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge sys_clk_i) {addr_i, rd_i} <= {a, 1'b1};
    @(posedge sys_clk_i) rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task cmp_reg(input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask
  task cmp_flag(input logic e, g);
    cmp_reg({31'h0, e}, {31'h0, g});
  endtask
  task wc(input logic [7:0] a, input logic [31:0] v, e);
    wr(a, v);
    rd(a);
    cmp_reg(e, d);
  endtask
  // apply one condition set to input 0, wait for the fault, then let it go
  task row(input logic [23:0] m, input logic c, lo, iv, ac, lu, g, input logic [8:0] lv, input logic e);
    int k;
    wr(8'h04, {8'h0, m});
    wr(8'h00, {31'h0, c});
    @(posedge sys_clk_i) {loss_r, inv_r, gp_r, lvl_r} <= {1'b0, lo, 1'b0, iv, 7'h7F, !g, lv};
    act_r <= ac ? 16'hFF00 : 16'hFFFF;
    luma_r <= lu ? 20'hFFC00 : 20'hFFFFF;
    for (k = 0; k < 300 && !(e && fault_o[0] === 1'b1); k++) @(posedge sys_clk_i);
    cmp_flag(e, fault_o[0]);
    cmp_flag(1'b0, fault_o[1]);
    @(posedge sys_clk_i) {loss_r, inv_r, gp_r, lvl_r, act_r, luma_r} <= {12'h0FF, 9'h040, 16'hFFFF, 20'hFFFFF};
    for (k = 0; k < 300 && fault_o[0] !== 1'b0; k++) @(posedge sys_clk_i);
    cmp_flag(1'b0, fault_o[0]);
    $display("test fault mask %h done", m);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // a hang ends the run as a failure
  initial begin
    #400000;
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (16) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    for (int i = 0; i < 28; i++) begin
      rd(8'((i % 2) * 64 + (i / 2) * 4));
      cmp_reg(dflt[i / 2], d);
    end
    $display("test defaults done");
    wc(8'h08, 32'h0, 32'h1);
    wc(8'h0C, 32'h9, 32'h6);
    wc(8'h0C, 32'h3FF, 32'h386);
    wc(8'h10, 32'h2, 32'h4);
    wc(8'h14, 32'hFF, 32'h78);
    wc(8'h18, 32'h2, 32'h3);
    wc(8'h5C, 32'h0, 32'h50);
    wc(8'h88, 32'h5, 32'h0); // unmapped place reads zero
    rd(8'h08);
    cmp_reg(32'h1, d);
    $display("test clamp done");
    wc(8'h14, 32'h0, 32'h0);
    wc(8'h28, 32'h1, 32'h1);
    wc(8'h2C, 32'h0, 32'h0);
    wc(8'h20, 32'h1, 32'h1);
    wc(8'h24, 32'h2, 32'h2);
    wc(8'h0C, 32'h6, 32'h6);
    row(24'h000001, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 9'h040, 1'b1);
    row(24'h000000, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 9'h040, 1'b0);
    row(24'h000009, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 9'h040, 1'b0);
    row(24'h000009, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 9'h040, 1'b1);
    row(24'h000002, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 9'h040, 1'b1);
    row(24'h000004, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 9'h040, 1'b1);
    row(24'h000080, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 9'h000, 1'b1);
    row(24'h000800, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 9'h1FF, 1'b1);
    row(24'h800000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 9'h040, 1'b1);
    // a zero hold keeps the fault until software clears it
    wr(8'h04, 32'h1);
    wc(8'h28, 32'h0, 32'h0);
    @(posedge sys_clk_i) loss_r <= 2'h1;
    @(posedge sys_clk_i) loss_r <= 2'h0;
    repeat (40) @(posedge sys_clk_i);
    rd(8'h30);
    cmp_reg(32'h01000000, d);
    wr(8'h30, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    #1 cmp_flag(1'b0, fault_o[0]);
    // input 1 faults on its own default enable
    @(posedge sys_clk_i) loss_r <= 2'h2;
    repeat (3) @(posedge sys_clk_i);
    #1 cmp_flag(1'b1, fault_o[1]);
    cmp_flag(1'b0, fault_o[0]);
    $display("test hold and clear done");
    report_and_stop;
  end
endmodule // av_fault_condition_monitor_test
`default_nettype wire
